// ==== common/pwm_timer_pkg.sv ====
// constants shared by the master/slave pwm timer unit
package pwm_timer_pkg;
    // ------------------------------------------------------------
    // structure
    // ------------------------------------------------------------
    localparam int CHANNELS  = 4;
    localparam int CNT_W     = 16;
    localparam int TAP_COUNT = 16;   // taps for clk/2^0 .. clk/2^15
    localparam int TAP_SEL_W = 4;
    localparam int DIV_W     = 15;
    localparam int SRC_W     = 2;
    // ------------------------------------------------------------
    // channel roles
    // ------------------------------------------------------------
    localparam int FIRST_MASTER  = 0;
    localparam int SECOND_MASTER = 2;
    localparam int ALT_SOURCE_CH = 1;
    localparam int LAST_CHANNEL  = 3;
    // ------------------------------------------------------------
    // channel 1 count clock sources
    // ------------------------------------------------------------
    localparam logic [SRC_W-1:0] SRC_PRESCALER = 2'h0;
    localparam logic [SRC_W-1:0] SRC_SUBCLOCK  = 2'h1;
    localparam logic [SRC_W-1:0] SRC_LOWSPEED  = 2'h2;
    // ------------------------------------------------------------
    // reset and step values
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_ONE   = 16'h0001;
    localparam logic [DIV_W-1:0] DIV_RESET   = 15'h0000;
    localparam logic [DIV_W-1:0] DIV_ONE     = 15'h0001;
endpackage

// ==== common/count_tick_if.sv ====
// carrier between the unit core and its count clock prescaler
`timescale 1ns/1ps
`default_nettype none
interface count_tick_if;
    logic                                  enable;
    logic [pwm_timer_pkg::TAP_COUNT-1:0]   tap;
    modport source (input enable, output tap);
    modport sink   (output enable, input tap);
endinterface
`default_nettype wire

// ==== core/count_prescaler.sv ====
// prescaler producing one-cycle tick pulses at clk/2^k
`timescale 1ns/1ps
`default_nettype none
module count_prescaler (
    input  wire logic        core_clk,
    input  wire logic        rst,
    count_tick_if.source     ticks
);
    logic [pwm_timer_pkg::DIV_W-1:0]     divCount_q;
    logic [pwm_timer_pkg::TAP_COUNT-1:0] tap_q;
    logic [pwm_timer_pkg::TAP_COUNT-1:0] tap_d;

    // ------------------------------------------------------------
    // divider chain
    // ------------------------------------------------------------
    // held at zero while the clock supply is off so taps restart aligned
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            divCount_q <= pwm_timer_pkg::DIV_RESET;
        end else if (!ticks.enable) begin
            divCount_q <= pwm_timer_pkg::DIV_RESET;
        end else begin
            divCount_q <= divCount_q + pwm_timer_pkg::DIV_ONE;
        end
    end

    // one tap per power of two, all low bits set marks the pulse
    assign tap_d[0] = ticks.enable;
    for (genvar k = 1; k < pwm_timer_pkg::TAP_COUNT; k++) begin : g_tap
        assign tap_d[k] = ticks.enable & (&divCount_q[k-1:0]);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tap_q <= '0;
        end else begin
            tap_q <= tap_d;
        end
    end
    assign ticks.tap = tap_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_tap_half_rate: assert property (@(posedge core_clk) disable iff (rst)
        tap_q[1] |=> !tap_q[1])
        else $error("clk/2 tap pulsed twice in a row");
    a_tap_gated_off: assert property (@(posedge core_clk) disable iff (rst)
        !ticks.enable |=> (tap_q == '0))
        else $error("tap pulsed while clock supply off");
endmodule
`default_nettype wire

// ==== core/pwm_timer_unit.sv ====
// four channel 16-bit timer unit in master/slave pwm output mode
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_unit #(
    parameter int CH = pwm_timer_pkg::CHANNELS,
    parameter int W  = pwm_timer_pkg::CNT_W
) (
    input  wire logic                                     core_clk,
    input  wire logic                                     rst,
    input  wire logic                                     unit0_clock_supply_enable,
    input  wire logic [CH-1:0][pwm_timer_pkg::TAP_SEL_W-1:0] tapSelect,
    input  wire logic [pwm_timer_pkg::SRC_W-1:0]          channel1Source,
    input  wire logic                                     subClockTick,
    input  wire logic                                     lowSpeedTick,
    input  wire logic                                     channel2IsMaster,
    input  wire logic [CH-1:0][W-1:0]                     channelDataReg,
    input  wire logic [CH-1:0]                            output_level_select,
    input  wire logic [CH-1:0]                            channel_start_trigger_reg,
    input  wire logic [CH-1:0]                            channel_stop_trigger_reg,
    output logic      [CH-1:0]                            timerOut,
    output logic      [CH-1:0]                            channelIrq,
    output logic      [CH-1:0]                            channelRunning,
    output logic      [CH-1:0][W-1:0]                     channelCountReg
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // channel 0 always a master, channel 2 on request
    function automatic logic isMaster(input int ch, input logic ch2m);
        return (ch == pwm_timer_pkg::FIRST_MASTER) ||
               ((ch == pwm_timer_pkg::SECOND_MASTER) && ch2m);
    endfunction

    // only the last channel may follow the second master
    function automatic int masterOf(input int ch, input logic ch2m);
        return ((ch == pwm_timer_pkg::LAST_CHANNEL) && ch2m) ?
               pwm_timer_pkg::SECOND_MASTER : pwm_timer_pkg::FIRST_MASTER;
    endfunction

    // ------------------------------------------------------------
    // count clock
    // ------------------------------------------------------------
    count_tick_if tickBus ();
    assign tickBus.enable = unit0_clock_supply_enable;

    count_prescaler u_prescaler (
        .core_clk (core_clk),
        .rst      (rst),
        .ticks    (tickBus.source)
    );

    logic [CH-1:0]        ownTick;
    logic [CH-1:0]        countTick;
    logic [CH-1:0]        startEv;
    logic [CH-1:0]        periodEv;
    logic [CH-1:0]        trig;
    logic [CH-1:0]        activeD;
    logic [CH-1:0]        running_q;
    logic [CH-1:0]        armed_q;
    logic [CH-1:0]        active_q;
    logic [CH-1:0]        irq_q;
    logic [CH-1:0]        out_q;
    logic [CH-1:0][W-1:0] cnt_q;

    for (genvar c = 0; c < CH; c++) begin : g_ch
        // alternate sources feed channel 1's own tick only, unused since channel 1 counts on channel 0's tick
        if (c == pwm_timer_pkg::ALT_SOURCE_CH) begin : g_alt
            assign ownTick[c] =
                (channel1Source == pwm_timer_pkg::SRC_SUBCLOCK) ? subClockTick :
                (channel1Source == pwm_timer_pkg::SRC_LOWSPEED) ? lowSpeedTick :
                tickBus.tap[tapSelect[c]];
        end else begin : g_tap
            assign ownTick[c] = tickBus.tap[tapSelect[c]];
        end

        // a slave counts on its master's clock so widths stay in period units
        assign countTick[c] = unit0_clock_supply_enable & running_q[c] &
            (isMaster(c, channel2IsMaster) ? ownTick[c]
                                           : ownTick[masterOf(c, channel2IsMaster)]);

        assign startEv[c] = unit0_clock_supply_enable & channel_start_trigger_reg[c] &
                            !channel_stop_trigger_reg[c] & !running_q[c];

        // period boundary: start, or the tick after reaching zero
        assign periodEv[c] = isMaster(c, channel2IsMaster) &
            (startEv[c] | (countTick[c] & (cnt_q[c] == pwm_timer_pkg::COUNT_RESET)));

        // slave is retriggered at every period boundary of its master
        assign trig[c] = !isMaster(c, channel2IsMaster) &
            (running_q[c] | startEv[c]) & !channel_stop_trigger_reg[c] &
            periodEv[masterOf(c, channel2IsMaster)];

        // next active level; zero data gives no pulse at all
        assign activeD[c] =
            (!unit0_clock_supply_enable || channel_stop_trigger_reg[c]) ? 1'b0 :
            trig[c] ? (channelDataReg[c] != pwm_timer_pkg::COUNT_RESET) :
            (countTick[c] && cnt_q[c] == pwm_timer_pkg::COUNT_ONE) ? 1'b0 :
            active_q[c];

        // ------------------------------------------------------------
        // run state
        // ------------------------------------------------------------
        // stop wins over a start written in the same cycle
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                running_q[c] <= 1'b0;
            end else if (!unit0_clock_supply_enable || channel_stop_trigger_reg[c]) begin
                running_q[c] <= 1'b0;
            end else if (channel_start_trigger_reg[c]) begin
                running_q[c] <= 1'b1;
            end
        end

        // ------------------------------------------------------------
        // counter
        // ------------------------------------------------------------
        // own 16-bit down counter per channel, reloaded from its data
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                cnt_q[c]   <= pwm_timer_pkg::COUNT_RESET;
                armed_q[c] <= 1'b0;
            end else if (!unit0_clock_supply_enable) begin
                armed_q[c] <= 1'b0;
            end else if (startEv[c] || periodEv[c] || trig[c]) begin
                cnt_q[c]   <= channelDataReg[c];
                armed_q[c] <= !isMaster(c, channel2IsMaster);
            end else if (countTick[c]) begin
                if (cnt_q[c] != pwm_timer_pkg::COUNT_RESET) begin
                    cnt_q[c] <= cnt_q[c] - pwm_timer_pkg::COUNT_ONE;
                end else begin
                    armed_q[c] <= 1'b0; // expired slave waits for next trigger
                end
            end
        end

        // ------------------------------------------------------------
        // interrupt and pin
        // ------------------------------------------------------------
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                irq_q[c]    <= 1'b0;
                active_q[c] <= 1'b0;
                out_q[c]    <= 1'b0;
            end else begin
                irq_q[c] <= periodEv[c] |
                    (armed_q[c] & !trig[c] & countTick[c] &
                     (cnt_q[c] == pwm_timer_pkg::COUNT_RESET));
                active_q[c] <= activeD[c];
                // inverted level turns the width into period minus slave data
                out_q[c] <= activeD[c] ^ output_level_select[c];
            end
        end
    end

    assign timerOut        = out_q;
    assign channelIrq      = irq_q;
    assign channelRunning  = running_q;
    assign channelCountReg = cnt_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_slave1_trig;
        trig[1] && channelDataReg[1] != pwm_timer_pkg::COUNT_RESET;
    endsequence
    sequence s_slave1_last_tick;
        countTick[1] && cnt_q[1] == pwm_timer_pkg::COUNT_ONE && !trig[1]
            && !channel_stop_trigger_reg[1] && unit0_clock_supply_enable;
    endsequence

    a_disabled_idle: assert property (
        !unit0_clock_supply_enable |=> (running_q == '0) && (irq_q == '0))
        else $error("unit active while clock supply off");
    a_master_reload: assert property (
        countTick[0] && cnt_q[0] == pwm_timer_pkg::COUNT_RESET |=>
            cnt_q[0] == $past(channelDataReg[0]) && irq_q[0])
        else $error("master did not reload at period end");
    a_start_irq: assert property (
        startEv[0] |=> irq_q[0] && running_q[0] && cnt_q[0] == $past(channelDataReg[0]))
        else $error("master start gave no interrupt");
    a_slave_irq: assert property (
        armed_q[1] && !trig[1] && countTick[1] && cnt_q[1] == pwm_timer_pkg::COUNT_RESET
            |=> irq_q[1] && !armed_q[1])
        else $error("slave expiry gave no interrupt");
    a_slave_rise: assert property (
        s_slave1_trig |=> timerOut[1] == !$past(output_level_select[1]))
        else $error("slave output not active at period start");
    a_slave_fall: assert property (
        s_slave1_last_tick |=> timerOut[1] == $past(output_level_select[1]))
        else $error("slave output not inactive at expiry");
    a_stop_halts: assert property (
        channel_stop_trigger_reg[1] |=> !running_q[1] && !active_q[1] ##1 !irq_q[1])
        else $error("stopped slave still active");
    a_third_follows_two: assert property (
        channel2IsMaster && running_q[3] && periodEv[0] && !periodEv[2]
            && !channel_stop_trigger_reg[3] |-> !trig[3])
        else $error("channel 3 followed the wrong master");
    a_third_reload: assert property (
        channel2IsMaster && running_q[3] && periodEv[2] && !channel_stop_trigger_reg[3]
            |=> cnt_q[3] == $past(channelDataReg[3]))
        else $error("channel 3 missed its master period start");
endmodule
`default_nettype wire

// ==== verification/pwm_load_model.sv ====
// external load on a timer output pin, measuring run lengths
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        pin,
    output logic      [15:0] highLen,
    output logic      [15:0] lowLen
);
    logic [15:0] runLen_q;
    logic        lastPin_q;
    // ------------------------------------------------------------
    // run length capture
    // ------------------------------------------------------------
    // on each level change latch how long the previous level stood
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            runLen_q  <= 16'h0000;
            lastPin_q <= 1'b0;
            highLen   <= 16'h0000;
            lowLen    <= 16'h0000;
        end else begin
            lastPin_q <= pin;
            if (pin !== lastPin_q) begin
                runLen_q <= 16'h0001;
                if (lastPin_q) highLen <= runLen_q;
                else lowLen <= runLen_q;
            end else begin
                runLen_q <= runLen_q + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the master/slave pwm timer unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic             core_clk = 1'b0;
    logic             rst = 1'b1;
    logic             en = 1'b1;
    logic [3:0][3:0]  tapSel = '0;
    logic [1:0]       srcSel = pwm_timer_pkg::SRC_PRESCALER;
    logic             subTick = 1'b0;
    logic             lowTick = 1'b0;
    logic             ch2Master = 1'b0;
    logic [3:0][15:0] dataReg = '0;
    logic [3:0]       levelSel = 4'h0;
    logic [3:0]       startReg = 4'h0;
    logic [3:0]       stopReg = 4'h0;
    logic [3:0]       timerOut;
    logic [3:0]       irq;
    logic [3:0]       running;
    logic [3:0][15:0] countReg;
    logic [15:0]      hi1, lo1, hi3, lo3;
    int               err_total = 0;
    int               comparisons = 0;
    // ------------------------------------------------------------
    // clock, design and loads
    // ------------------------------------------------------------
    always #50 core_clk = ~core_clk;
    pwm_timer_unit i_dut (.core_clk(core_clk), .rst(rst), .unit0_clock_supply_enable(en),
        .tapSelect(tapSel), .channel1Source(srcSel), .subClockTick(subTick),
        .lowSpeedTick(lowTick), .channel2IsMaster(ch2Master), .channelDataReg(dataReg),
        .output_level_select(levelSel), .channel_start_trigger_reg(startReg),
        .channel_stop_trigger_reg(stopReg), .timerOut(timerOut), .channelIrq(irq),
        .channelRunning(running), .channelCountReg(countReg));
    pwm_load_model i_load1 (.core_clk(core_clk), .rst(rst), .pin(timerOut[1]),
        .highLen(hi1), .lowLen(lo1));
    pwm_load_model i_load3 (.core_clk(core_clk), .rst(rst), .pin(timerOut[3]),
        .highLen(hi3), .lowLen(lo3));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle trigger pulse; returns settled in the first answer cycle
    task automatic trig(input logic [3:0] s, input logic [3:0] p);
        @(posedge core_clk);
        startReg <= s;
        stopReg  <= p;
        @(posedge core_clk);
        startReg <= 4'h0;
        stopReg  <= 4'h0;
        #1;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #(5000 * 100);
        err_total++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        dataReg[0] <= 16'h0003;
        dataReg[1] <= 16'h0001;
        cyc(2);
        check("idle running", {12'h000, running}, 16'h0000);
        // walk: master D=3, slave D=1, started together
        trig(4'h3, 4'h0);
        check("start irq", {12'h000, irq}, 16'h0001);
        check("running", {12'h000, running}, 16'h0003);
        check("master count", countReg[0], 16'h0003);
        check("slave count", countReg[1], 16'h0001);
        check("slave out", {15'h0000, timerOut[1]}, 16'h0001);
        cyc(2);
        check("slave irq", {12'h000, irq}, 16'h0002);
        cyc(2);
        check("reload irq", {12'h000, irq}, 16'h0001);
        cyc(20);
        check("high width", hi1, 16'h0001);
        check("period rest", lo1, 16'h0003);
        // width taken anew each period
        @(posedge core_clk);
        dataReg[1] <= 16'h0002;
        cyc(20);
        check("new width", hi1, 16'h0002);
        check("new rest", lo1, 16'h0002);
        // active low output
        @(posedge core_clk);
        dataReg[1] <= 16'h0001;
        levelSel[1] <= 1'b1;
        cyc(20);
        check("low width", lo1, 16'h0001);
        check("low rest", hi1, 16'h0003);
        // count clock tap clk/4, slave follows its master
        @(posedge core_clk);
        tapSel[0] <= 4'h2;
        cyc(60);
        check("tap low", lo1, 16'h0004);
        check("tap high", hi1, 16'h000C);
        @(posedge core_clk);
        tapSel[0] <= 4'h0;
        // stop both, pin returns to its inactive level
        trig(4'h0, 4'h3);
        check("stopped", {12'h000, running}, 16'h0000);
        check("idle pins", {14'h0000, timerOut[1:0]}, 16'h0002);
        // start refused while supply enable is low
        @(posedge core_clk);
        en <= 1'b0;
        trig(4'h3, 4'h0);
        check("gated", {12'h000, running}, 16'h0000);
        @(posedge core_clk);
        en <= 1'b1;
        cyc(2);
        trig(4'h3, 4'h3);
        check("stop wins", {12'h000, running}, 16'h0000);
        // channel 2 as master of channel 3
        @(posedge core_clk);
        ch2Master <= 1'b1;
        dataReg[2] <= 16'h0004;
        dataReg[3] <= 16'h0002;
        // channel 0 runs too, so its boundaries must not retrigger channel 3
        trig(4'hD, 4'h0);
        check("ch2 irq", {12'h000, irq}, 16'h0005);
        check("ch2 run", {12'h000, running}, 16'h000D);
        cyc(30);
        check("ch3 high", hi3, 16'h0002);
        check("ch3 rest", lo3, 16'h0003);
        report_and_stop();
    end
endmodule
`default_nettype wire
